/* File: srtc_slave.sv */
// Single-wire seconds clock slave with its counter-write FIFO.
// Assumes an external pull-up on the data line and a tick input
// that pulses once per second from the crystal oscillator domain.
//
// What this block does
// - Interrupt pulses only while enable bit set.
// - 32-bit seconds counter increments, wraps to zero.
// - Transfers start at control byte, no addressing.
// - Read-clock snapshots counter after last command bit.
// - Read sends control then counter bytes, repeating.
// - Reset pulse abandons read transfer anytime.
// - Written control byte takes effect immediately.
// - Written counter bytes load on next reset.
// - Clock write may raise an immediate interrupt.
// - Stopped oscillator freezes counter as storage.
// - Long low line never resets control or counter.
// - Clock commands only after addressing command.
// - Read-identity sends family, serial, check byte.
// - Match-identity mismatch ignores bus until reset.
// - Search sends bit, complement, reads choice.
// - Skip-identity selects device without identity.
// - Presence pulse follows reset after short wait.
// - Falling edge starts delay, write sampled after.
// - Read zero holds line low, one releases.
// - All bytes travel least significant bit first.
// - Control bits six to four pick interval.
// - Oscillator bits mirror state, bit three wins.
`timescale 1ns/1ps
`default_nettype none
`include "srtc_consts.svh"

module srtc_fifo #(
  parameter int P_W = 8,
  parameter int P_D = 32
) (
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_wr_valid,
  output logic                o_wr_ready,
  input  wire logic [P_W-1:0] i_wr_data,
  output logic                o_rd_valid,
  input  wire logic           i_rd_ready,
  output logic      [P_W-1:0] o_rd_data
);
  localparam int AW = $clog2(P_D);

  logic [P_W-1:0] mem [P_D];
  logic [AW:0]    wp_ff;
  logic [AW:0]    rp_ff;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // Depth must be a power of two; the extra pointer bit tells full.
  assign empty = (wp_ff == rp_ff);
  assign full = (wp_ff[AW] != rp_ff[AW]) &&
                (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign push = i_wr_valid && !full;
  assign pop = i_rd_ready && !empty;
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign o_rd_data = mem[rp_ff[AW-1:0]];

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wp_ff[AW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
    end
    else
    begin
      wp_ff <= wp_ff + (AW+1)'(push);
      rp_ff <= rp_ff + (AW+1)'(pop);
    end
  end
endmodule

module srtc_slave #(
  parameter logic [63:0] P_ROM_ID = 64'h3c00_0000_0000_a501,
  parameter int P_RST_DET_CYC = `SRTC_RST_DET_US * `SRTC_CLK_MHZ,
  parameter int P_PRES_WAIT_CYC = `SRTC_PRES_WAIT_US * `SRTC_CLK_MHZ,
  parameter int P_PRES_LOW_CYC = `SRTC_PRES_LOW_US * `SRTC_CLK_MHZ,
  parameter int P_SLOT_DLY_CYC = `SRTC_SLOT_DLY_US * `SRTC_CLK_MHZ,
  parameter int P_INT_LOW_CYC = `SRTC_INT_LOW_US * `SRTC_CLK_MHZ,
  parameter int P_FIFO_DEPTH = 32
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_dq,
  output logic      o_dq_out,
  output logic      o_dq_oe,
  input  wire logic i_osc_tick,
  output logic      o_int_out,
  output logic      o_int_oe,
  output logic [7:0] o_ctrl,
  output logic [31:0] o_seconds
);
  import srtc_pkg::*;

  // The identity value above is arbitrary.
  localparam logic [17:0] RST_M1 = 18'(P_RST_DET_CYC - 1);
  localparam logic [17:0] PW_M1 = 18'(P_PRES_WAIT_CYC - 1);
  localparam logic [17:0] PL_M1 = 18'(P_PRES_LOW_CYC - 1);
  localparam logic [17:0] DLY_M1 = 18'(P_SLOT_DLY_CYC - 1);
  localparam logic [17:0] INT_LEN = 18'(P_INT_LOW_CYC);

  function automatic logic [7:0] rd_sel(input logic [2:0] idx,
                                        input logic [7:0] ctl,
                                        input logic [31:0] b);
    case (idx)
      3'h1: rd_sel = b[7:0];
      3'h2: rd_sel = b[15:8];
      3'h3: rd_sel = b[23:16];
      3'h4: rd_sel = b[31:24];
      default: rd_sel = ctl;
    endcase
  endfunction

  function automatic logic [31:0] int_mask(input logic [2:0] sel);
    case (sel)
      3'h1: int_mask = 32'h0000_0003;
      3'h2: int_mask = 32'h0000_001f;
      3'h3: int_mask = 32'h0000_003f;
      3'h4: int_mask = 32'h0000_07ff;
      3'h5: int_mask = 32'h0000_0fff;
      3'h6: int_mask = 32'h0000_ffff;
      3'h7: int_mask = 32'h0001_ffff;
      default: int_mask = 32'h0000_0000;
    endcase
  endfunction

  logic [2:0]  dq_sync_ff;
  logic [2:0]  tk_sync_ff;
  srtc_line_t  line_ff;
  srtc_line_t  nxt_line;
  logic [17:0] tmr_ff;
  logic [17:0] nxt_tmr;
  logic        dq_oe_ff;
  srtc_seq_t   seq_ff;
  srtc_seq_t   nxt_seq;
  logic [7:0]  sh_ff;
  logic [5:0]  bcnt_ff;
  logic [5:0]  nxt_bcnt;
  logic [1:0]  ph_ff;
  logic [1:0]  nxt_ph;
  logic [2:0]  idx_ff;
  logic [2:0]  nxt_idx;
  logic        ie_ff;
  logic [2:0]  isel_ff;
  logic        osc_ff;
  logic [31:0] cnt_ff;
  logic [31:0] buf_ff;
  logic        load_ff;
  logic [17:0] int_tmr_ff;
  logic        int_oe_ff;
  wire         dq_lvl;
  wire         dq_fall;
  wire         dq_rise;
  wire         tick_ev;
  wire         rst_ev;
  wire         bit_ev;
  wire         byte_done;
  wire  [7:0]  rx_byte;
  wire         id_bit;
  wire  [7:0]  ctl_rd;
  wire  [7:0]  rd_byte;
  wire         tx_bit;
  wire         slot_tx;
  wire         drive;
  wire         snap;
  wire         ctl_wr;
  wire         push;
  wire         pop;
  wire         fifo_valid;
  wire  [7:0]  fifo_data;
  wire         load_fin;
  wire         cnt_inc;
  wire  [31:0] cnt_plus;
  wire         irq_hit;
  wire  [17:0] nxt_int_tmr;

  // Line and oscillator tick pass two flops before any use.
  assign dq_lvl = dq_sync_ff[1];
  assign dq_fall = dq_sync_ff[2] && !dq_sync_ff[1];
  assign dq_rise = !dq_sync_ff[2] && dq_sync_ff[1];
  assign tick_ev = tk_sync_ff[1] && !tk_sync_ff[2];

  // Only a long low on the line resets the link, never the core.
  assign rst_ev = (line_ff == L_SLOT) && !dq_lvl && (tmr_ff >= RST_M1);
  assign bit_ev = (line_ff == L_SLOT) && (tmr_ff == DLY_M1);
  assign byte_done = (bcnt_ff[2:0] == 3'h7);
  assign rx_byte = {dq_lvl, sh_ff[7:1]};

  assign id_bit = P_ROM_ID[bcnt_ff];
  assign ctl_rd = {ie_ff, isel_ff, osc_ff, osc_ff, 2'b00};
  assign rd_byte = rd_sel(idx_ff, ctl_rd, buf_ff);
  assign tx_bit = (seq_ff == S_RDID) ? id_bit :
                  (seq_ff == S_SEARCH) ? (id_bit ^ ph_ff[0]) :
                  rd_byte[bcnt_ff[2:0]];
  assign slot_tx = (seq_ff == S_RDID) || (seq_ff == S_RDCLK) ||
                   ((seq_ff == S_SEARCH) && (ph_ff != 2'h2));
  assign drive = (line_ff == L_PLOW) ||
                 ((line_ff == L_SLOT) && slot_tx && !tx_bit &&
                  (tmr_ff <= DLY_M1));
  assign o_dq_oe = dq_oe_ff;
  assign o_dq_out = 1'b0;

  assign snap = bit_ev && (seq_ff == S_FNCMD) && byte_done &&
                (rx_byte == `SRTC_CMD_RD_CLK);
  assign ctl_wr = bit_ev && (seq_ff == S_WRCLK) && byte_done &&
                  (idx_ff == 3'h0);
  assign push = bit_ev && (seq_ff == S_WRCLK) && byte_done &&
                (idx_ff != 3'h0);
  assign pop = load_ff && fifo_valid;
  assign load_fin = load_ff && !fifo_valid;
  assign cnt_inc = tick_ev && osc_ff;
  assign cnt_plus = cnt_ff + 32'h1;

  assign irq_hit = ie_ff &&
                   ((cnt_inc && !load_fin &&
                     ((cnt_plus & int_mask(isel_ff)) == 32'h0)) ||
                    (load_fin &&
                     ((buf_ff & int_mask(isel_ff)) == 32'h0)));
  assign nxt_int_tmr = irq_hit ? INT_LEN :
                       (int_tmr_ff != 18'h0) ? int_tmr_ff - 18'h1 :
                       18'h0;
  assign o_int_oe = int_oe_ff;
  assign o_int_out = 1'b0;
  assign o_ctrl = ctl_rd;
  assign o_seconds = cnt_ff;

  srtc_fifo #(
    .P_W (8),
    .P_D (P_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_valid (push),
    .o_wr_ready (),
    .i_wr_data  (rx_byte),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (load_ff),
    .o_rd_data  (fifo_data)
  );

  always_comb
  begin
    nxt_line = line_ff;
    nxt_tmr = (tmr_ff == 18'h3ffff) ? tmr_ff : tmr_ff + 18'h1;
    case (line_ff)
      L_IDLE:
      begin
        if (dq_fall)
        begin
          nxt_line = L_SLOT;
          nxt_tmr = 18'h0;
        end
      end
      L_SLOT:
      begin
        if (rst_ev)
        begin
          nxt_line = L_RSTW;
        end
        else if (dq_lvl && (tmr_ff > DLY_M1))
        begin
          nxt_line = L_IDLE;
        end
      end
      L_RSTW:
      begin
        if (dq_rise)
        begin
          nxt_line = L_PWAIT;
          nxt_tmr = 18'h0;
        end
      end
      L_PWAIT:
      begin
        if (tmr_ff == PW_M1)
        begin
          nxt_line = L_PLOW;
          nxt_tmr = 18'h0;
        end
      end
      L_PLOW:
      begin
        if (tmr_ff == PL_M1)
        begin
          nxt_line = L_IDLE;
        end
      end
      default: nxt_line = L_IDLE;
    endcase
  end

  always_comb
  begin
    nxt_seq = seq_ff;
    nxt_bcnt = bcnt_ff;
    nxt_ph = ph_ff;
    nxt_idx = idx_ff;
    if (rst_ev)
    begin
      nxt_seq = S_ROMCMD;
      nxt_bcnt = 6'h0;
      nxt_ph = 2'h0;
      nxt_idx = 3'h0;
    end
    else if (bit_ev)
    begin
      nxt_bcnt = bcnt_ff + 6'h1;
      case (seq_ff)
        S_ROMCMD:
        begin
          if (byte_done)
          begin
            nxt_bcnt = 6'h0;
            case (rx_byte)
              `SRTC_CMD_READ_ID: nxt_seq = S_RDID;
              `SRTC_CMD_MATCH_ID: nxt_seq = S_MATCH;
              `SRTC_CMD_SEARCH_ID: nxt_seq = S_SEARCH;
              `SRTC_CMD_SKIP_ID: nxt_seq = S_FNCMD;
              default: nxt_seq = S_DEAD;
            endcase
          end
        end
        S_FNCMD:
        begin
          if (byte_done)
          begin
            nxt_bcnt = 6'h0;
            case (rx_byte)
              `SRTC_CMD_RD_CLK: nxt_seq = S_RDCLK;
              `SRTC_CMD_WR_CLK: nxt_seq = S_WRCLK;
              default: nxt_seq = S_DEAD;
            endcase
          end
        end
        S_RDID:
        begin
          if (bcnt_ff == `SRTC_ID_LAST)
          begin
            nxt_seq = S_FNCMD;
          end
        end
        S_MATCH:
        begin
          if (dq_lvl != id_bit)
          begin
            nxt_seq = S_DEAD;
          end
          else if (bcnt_ff == `SRTC_ID_LAST)
          begin
            nxt_seq = S_FNCMD;
          end
        end
        S_SEARCH:
        begin
          if (ph_ff != 2'h2)
          begin
            nxt_ph = ph_ff + 2'h1;
            nxt_bcnt = bcnt_ff;
          end
          else
          begin
            nxt_ph = 2'h0;
            if (dq_lvl != id_bit)
            begin
              nxt_seq = S_DEAD;
            end
            else if (bcnt_ff == `SRTC_ID_LAST)
            begin
              nxt_seq = S_FNCMD;
            end
          end
        end
        S_RDCLK:
        begin
          if (byte_done)
          begin
            nxt_idx = (idx_ff == `SRTC_LAST_BYTE) ? 3'h0 :
                      idx_ff + 3'h1;
          end
        end
        S_WRCLK:
        begin
          if (byte_done)
          begin
            nxt_idx = 3'h1;
          end
        end
        default: nxt_bcnt = bcnt_ff;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dq_sync_ff <= 3'h7;
      tk_sync_ff <= 3'h0;
      line_ff <= L_IDLE;
      tmr_ff <= 18'h0;
      dq_oe_ff <= 1'b0;
      int_tmr_ff <= 18'h0;
      int_oe_ff <= 1'b0;
    end
    else
    begin
      dq_sync_ff <= {dq_sync_ff[1:0], i_dq};
      tk_sync_ff <= {tk_sync_ff[1:0], i_osc_tick};
      line_ff <= nxt_line;
      tmr_ff <= nxt_tmr;
      dq_oe_ff <= drive;
      int_tmr_ff <= nxt_int_tmr;
      int_oe_ff <= (nxt_int_tmr != 18'h0);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seq_ff <= S_DEAD;
      sh_ff <= 8'h00;
      bcnt_ff <= 6'h0;
      ph_ff <= 2'h0;
      idx_ff <= 3'h0;
    end
    else
    begin
      seq_ff <= nxt_seq;
      sh_ff <= bit_ev ? rx_byte : sh_ff;
      bcnt_ff <= nxt_bcnt;
      ph_ff <= nxt_ph;
      idx_ff <= nxt_idx;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ie_ff <= 1'(`SRTC_CTL_RST >> `SRTC_CTL_IE_BIT);
      isel_ff <= 3'h0;
      osc_ff <= 1'b0;
    end
    else if (ctl_wr)
    begin
      ie_ff <= rx_byte[`SRTC_CTL_IE_BIT];
      isel_ff <= rx_byte[`SRTC_CTL_IS_HI:`SRTC_CTL_IS_LO];
      osc_ff <= rx_byte[`SRTC_CTL_OSC_BIT];
    end
  end

  // The buffer serves both the read snapshot and the write assembly.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_ff <= 32'h0;
      buf_ff <= 32'h0;
      load_ff <= 1'b0;
    end
    else
    begin
      if (load_fin)
      begin
        cnt_ff <= buf_ff;
      end
      else if (cnt_inc)
      begin
        cnt_ff <= cnt_plus;
      end
      if (snap)
      begin
        buf_ff <= cnt_ff;
      end
      else if (pop)
      begin
        buf_ff <= {fifo_data, buf_ff[31:8]};
      end
      if (rst_ev && (seq_ff == S_WRCLK) && fifo_valid)
      begin
        load_ff <= 1'b1;
      end
      else if (load_fin)
      begin
        load_ff <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_irq_gate: assert property (
    $rose(int_oe_ff) |-> $past(ie_ff))
    else $error("Interrupt pulse started while disabled.");
  a_cnt_inc: assert property (
    (cnt_inc && !load_fin) |=> (cnt_ff == $past(cnt_ff) + 32'h1))
    else $error("Seconds counter did not advance on tick.");
  a_snap_take: assert property (
    snap |=> (buf_ff == $past(cnt_ff)))
    else $error("Read command did not snapshot the counter.");
  a_ctl_now: assert property (
    ctl_wr |=> (ie_ff == $past(rx_byte[7])) && (osc_ff == $past(rx_byte[3])))
    else $error("Control byte not applied at once.");
  a_cnt_load: assert property (
    load_fin |=> (cnt_ff == $past(buf_ff)) && !load_ff)
    else $error("Written counter value not loaded.");
  a_cnt_hold: assert property (
    (!osc_ff && !load_fin) |=> $stable(cnt_ff))
    else $error("Counter moved with oscillator stopped.");
  a_dead_quiet: assert property (
    (seq_ff == S_DEAD) && (line_ff == L_SLOT) |=> !dq_oe_ff)
    else $error("Deselected device drove the line.");
  a_pres_low: assert property (
    (line_ff == L_PWAIT) && (tmr_ff == PW_M1) |-> ##2 o_dq_oe)
    else $error("Presence pulse missing after wait.");
  a_read_zero: assert property (
    (line_ff == L_SLOT) && slot_tx && !tx_bit && (tmr_ff < DLY_M1)
    |=> dq_oe_ff)
    else $error("Zero read slot not held low.");
  a_seq_reset: assert property (
    rst_ev |=> (seq_ff == S_ROMCMD) && (line_ff == L_RSTW))
    else $error("Reset did not return to addressing.");
endmodule

`default_nettype wire

/* File: srtc_consts.svh */
// Constants for the single-wire seconds clock slave.
// Assumes the including file uses the 200 MHz reference clock.
`ifndef SRTC_CONSTS_SVH
`define SRTC_CONSTS_SVH

`define SRTC_CLK_MHZ 200
`define SRTC_RST_DET_US 240
`define SRTC_PRES_WAIT_US 30
`define SRTC_PRES_LOW_US 120
`define SRTC_SLOT_DLY_US 30
`define SRTC_INT_LOW_US 100

`define SRTC_CMD_READ_ID 8'h33
`define SRTC_CMD_MATCH_ID 8'h55
`define SRTC_CMD_SEARCH_ID 8'hf0
`define SRTC_CMD_SKIP_ID 8'hcc
`define SRTC_CMD_RD_CLK 8'h66
`define SRTC_CMD_WR_CLK 8'h99

`define SRTC_CTL_IE_BIT 7
`define SRTC_CTL_IS_HI 6
`define SRTC_CTL_IS_LO 4
`define SRTC_CTL_OSC_BIT 3
`define SRTC_CTL_RST 8'h00
`define SRTC_ID_LAST 6'h3f
`define SRTC_LAST_BYTE 3'h4

`endif

/* File: srtc_pkg.sv */
// Types for the single-wire seconds clock slave.
// Assumes nothing of its surroundings.
package srtc_pkg;

  typedef enum logic [2:0]
  {
    L_IDLE, L_SLOT, L_RSTW, L_PWAIT, L_PLOW
  } srtc_line_t;

  typedef enum logic [2:0]
  {
    S_DEAD, S_ROMCMD, S_RDID, S_MATCH, S_SEARCH, S_FNCMD, S_RDCLK, S_WRCLK
  } srtc_seq_t;

endpackage

/* File: srtc_master.sv */
// Bus master model driving the single-wire line of the seconds clock slave.
// Assumes the bench resolves the line from both pull-down enables.
`timescale 1ns/1ps
`default_nettype none

module srtc_master (
  input  wire logic       i_ref_clk,
  input  wire logic       i_dq,
  output logic            o_dq_oe,
  output logic            o_got,
  output logic [7:0]      o_byte
);
  initial
  begin
    o_dq_oe = 1'b0;
    o_got = 1'b0;
    o_byte = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // Reset pulse, then the line is sampled in the wait and in the presence.
  task automatic bus_reset(input int n, output logic pw, output logic pl);
    o_dq_oe = 1'b1;
    hold(n);
    o_dq_oe = 1'b0;
    hold(20);
    pw = i_dq;
    hold(80);
    pl = i_dq;
    hold(150);
  endtask

  // One slot: a short low for a one or a read, a long low for a zero.
  task automatic slot(input logic b, output logic s);
    o_dq_oe = 1'b1;
    hold(b ? 4 : 60);
    o_dq_oe = 1'b0;
    hold(b ? 16 : 10);
    s = i_dq;
    hold(b ? 40 : 0);
  endtask

  task automatic send(input logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++)
      slot(v[i], s);
  endtask

  task automatic recv(output logic [7:0] v);
    for (int i = 0; i < 8; i++)
      slot(1'b1, v[i]);
    o_byte = v;
    o_got = 1'b1;
    hold(1);
    o_got = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the seconds clock slave and its bus master model.
// Assumes a pull-up on the line and shortened bus timing parameters.
`timescale 1ns/1ps
`default_nettype none
`include "srtc_consts.svh"

module testbench;
  localparam logic [63:0] ID = 64'h3c00_0000_0000_a501; // Arbitrary value.
  logic        i_ref_clk, i_rst_n, i_osc_tick;
  logic        dq_oe, m_oe, got, dq, int_oe, dq_out, int_out, pw, pl;
  logic [7:0]  ctrl, got_byte;
  logic [31:0] secs, val, cnt;
  logic [7:0]  exp_q[$];
  int          err_total, checked;

  assign dq = ~(dq_oe | m_oe);

  srtc_slave #(
    .P_RST_DET_CYC   (400),
    .P_PRES_WAIT_CYC (40),
    .P_PRES_LOW_CYC  (100),
    .P_SLOT_DLY_CYC  (40),
    .P_INT_LOW_CYC   (20)
  ) uut (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_dq       (dq),
    .o_dq_out   (dq_out),
    .o_dq_oe    (dq_oe),
    .i_osc_tick (i_osc_tick),
    .o_int_out  (int_out),
    .o_int_oe   (int_oe),
    .o_ctrl     (ctrl),
    .o_seconds  (secs)
  );

  srtc_master master (
    .i_ref_clk (i_ref_clk),
    .i_dq      (dq),
    .o_dq_oe   (m_oe),
    .o_got     (got),
    .o_byte    (got_byte)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge got)
  begin
    if (exp_q.size() == 0)
      check("unexpected byte", 32'h1, 32'h0);
    else
      check("read byte", {24'h0, got_byte}, {24'h0, exp_q.pop_front()});
  end

  task automatic rst_bus(input int n);
    master.bus_reset(n, pw, pl);
    check("presence wait", pw, 1'b1);
    check("presence low", pl, 1'b0);
  endtask

  task automatic rd(input logic [7:0] e);
    logic [7:0] t;
    exp_q.push_back(e);
    master.recv(t);
  endtask

  task automatic tick(input logic run, input logic irq);
    i_osc_tick = 1'b1;
    master.hold(4);
    i_osc_tick = 1'b0;
    master.hold(4);
    if (run)
      cnt = cnt + 32'h1;
    check("seconds", secs, cnt);
    check("interrupt", int_oe, irq);
  endtask

  task automatic wr_clk(input logic [7:0] c, ec, input logic [31:0] v);
    rst_bus(500);
    master.send(`SRTC_CMD_SKIP_ID);
    master.send(`SRTC_CMD_WR_CLK);
    master.send(c);
    check("ctrl", ctrl, ec);
    for (int i = 0; i < 4; i++)
      master.send(v[8*i+:8]);
    check("seconds held", secs, cnt);
    rst_bus(500);
    cnt = v;
    check("seconds loaded", secs, cnt);
  endtask

  task automatic rd_clk(input logic [7:0] ec);
    logic [39:0] w;
    w = {cnt, ec};
    rst_bus(500);
    master.send(`SRTC_CMD_SKIP_ID);
    master.send(`SRTC_CMD_RD_CLK);
    tick(1'b1, 1'b1);
    for (int p = 0; p < 10; p++)
      rd(w[8*(p%5)+:8]);
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    i_osc_tick = 1'b0;
    err_total = 0;
    checked = 0;
    cnt = 32'h0;
    void'($urandom(64));
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    check("ctrl reset", ctrl, 8'h00);
    check("seconds reset", secs, 32'h0);
    master.hold(4);
    rst_bus(500);
    master.send(`SRTC_CMD_RD_CLK);
    rd(8'hff);
    val = $urandom();
    wr_clk(8'h8c, 8'h8c, val);
    tick(1'b1, 1'b1);
    rd_clk(8'h8c);
    wr_clk(8'h8c, 8'h8c, 32'hffffffff);
    tick(1'b1, 1'b1);
    wr_clk(8'h08, 8'h0c, val);
    tick(1'b1, 1'b0);
    wr_clk(8'h9c, 8'h9c, 32'h2);
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b1);
    wr_clk(8'hfc, 8'hfc, 32'hffff);
    tick(1'b1, 1'b0);
    wr_clk(8'h04, 8'h00, val);
    tick(1'b0, 1'b0);
    rst_bus(500);
    master.send(`SRTC_CMD_SKIP_ID);
    master.send(`SRTC_CMD_RD_CLK);
    for (int i = 0; i < 3; i++)
      master.slot(1'b1, pw);
    rst_bus(3000);
    check("seconds kept", secs, cnt);
    master.send(`SRTC_CMD_READ_ID);
    for (int i = 0; i < 8; i++)
      rd(ID[8*i+:8]);
    rst_bus(500);
    master.send(`SRTC_CMD_MATCH_ID);
    for (int i = 0; i < 8; i++)
      master.send(ID[8*i+:8] ^ {7'h0, i == 0});
    master.send(`SRTC_CMD_RD_CLK);
    rd(8'hff);
    rst_bus(500);
    master.send(`SRTC_CMD_MATCH_ID);
    for (int i = 0; i < 8; i++)
      master.send(ID[8*i+:8]);
    master.send(`SRTC_CMD_RD_CLK);
    rd(8'h00);
    rst_bus(500);
    master.send(`SRTC_CMD_SEARCH_ID);
    for (int i = 0; i < 64; i++)
    begin
      master.slot(1'b1, pw);
      master.slot(1'b1, pl);
      check("search bit", pw, ID[i]);
      check("search inverse", pl, !ID[i]);
      master.slot(ID[i], pw);
    end
    master.send(`SRTC_CMD_RD_CLK);
    rd(8'h00);
    master.hold(10);
    check("line data", dq_out, 1'b0);
    check("interrupt data", int_out, 1'b0);
    check("bytes left", exp_q.size(), 32'h0);
    end_sim;
  end

  initial
  begin
    #500_000;
    check("timeout", 1'b1, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
